// ---- verilog/dcf_top.sv ----
// Purpose: Dual-clock FIFO with flag timing, first-word latency and cascade outputs
// Assumes: DEPTH is a power of two; link clocks far slower than clock_in
// Notes: Link clocks are sampled pins, edges found in the clock_in domain
`include "dcf_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module dcf_top #(
    parameter int unsigned DEPTH = `DCF_DEPTH,
    parameter int unsigned AW = $clog2(DEPTH)
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Write side pins
    input wire logic write_clk_in,
    input wire logic write_en_n_in,
    input wire dcf_pkg::dcf_word_t data_in,
    // Read side pins
    input wire logic read_clk_in,
    input wire logic read_en_n_in,
    input wire logic output_drive_enable_n_in,
    output var dcf_pkg::dcf_word_t data_out,
    output logic data_oe_out,
    // Control pins
    input wire logic fifo_reset_n_in,
    input wire logic retransmit_n_in,
    input wire logic sync_flag_select_in,
    input wire logic [AW-1:0] almost_empty_offset_in,
    input wire logic [AW-1:0] almost_full_offset_in,
    // Indicators
    output logic full_indicator_n_out,
    output logic empty_indicator_n_out,
    output logic almost_empty_indicator_n_out,
    output logic almost_full_indicator_n_out,
    output logic write_cascade_out,
    output logic read_cascade_out
);
    import dcf_pkg::*;

    localparam int unsigned W = `DCF_WIDTH;
    localparam int unsigned SW = 8 + W + 2 * AW;
    localparam int unsigned RST_CYC = `DCF_CEIL_CYC(`DCF_RST_MIN_NS);
    localparam int unsigned RTX_CYC = `DCF_CEIL_CYC(`DCF_RTX_MIN_NS);
    localparam int unsigned RTR_CYC = `DCF_CEIL_CYC(`DCF_RTR_NS);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

    // ****************************************************
    // Helpers
    // ****************************************************
    function automatic logic f_at_last(input logic [AW-1:0] ptr);
        return ptr == AW'(DEPTH - 1);
    endfunction : f_at_last

    function automatic logic [7:0] f_sat_inc(input logic [7:0] cnt, input logic low,
                                             input int unsigned lim);
        if (!low) begin
            return '0;
        end
        return (cnt < 8'(lim)) ? cnt + 8'h01 : cnt;
    endfunction : f_sat_inc

    // ****************************************************
    // Pin synchronisers
    // ****************************************************
    logic [SW-1:0] pin_s1_q;
    logic [SW-1:0] pin_s2_q;
    logic wclk_s3_q;
    logic rclk_s3_q;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            // Idle levels: no false clock edge, pin reset or retransmit follows
            pin_s1_q <= '1;
            pin_s2_q <= '1;
            wclk_s3_q <= 1'b1;
            rclk_s3_q <= 1'b1;
        end else begin
            pin_s1_q <= {write_clk_in, read_clk_in, write_en_n_in, read_en_n_in,
                         output_drive_enable_n_in, fifo_reset_n_in, retransmit_n_in,
                         sync_flag_select_in, data_in, almost_empty_offset_in,
                         almost_full_offset_in};
            pin_s2_q <= pin_s1_q;
            wclk_s3_q <= pin_s2_q[SW-1];
            rclk_s3_q <= pin_s2_q[SW-2];
        end
    end

    logic wclk_s;
    logic rclk_s;
    logic wen_n_s;
    logic ren_n_s;
    logic oe_n_s;
    logic frst_n_s;
    logic rtx_n_s;
    logic sel_s;
    dcf_word_t data_s;
    logic [AW-1:0] ae_off_s;
    logic [AW-1:0] af_off_s;
    assign {wclk_s, rclk_s, wen_n_s, ren_n_s, oe_n_s, frst_n_s, rtx_n_s,
            sel_s, data_s, ae_off_s, af_off_s} = pin_s2_q;

    logic wclk_rise;
    logic rclk_rise;
    logic sync_mode;
    assign wclk_rise = wclk_s & ~wclk_s3_q;
    assign rclk_rise = rclk_s & ~rclk_s3_q;
    assign sync_mode = ~sel_s;

    // ****************************************************
    // Reset and retransmit pulse filters
    // ****************************************************
    logic [7:0] rst_lo_q;
    logic [7:0] rtx_lo_q;
    logic fifo_clr;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_lo_q <= '0;
            rtx_lo_q <= '0;
        end else begin
            rst_lo_q <= f_sat_inc(rst_lo_q, ~frst_n_s, RST_CYC);
            rtx_lo_q <= f_sat_inc(rtx_lo_q, ~rtx_n_s, RTX_CYC);
        end
    end

    // Acts only after the low level has lasted the minimum width
    assign fifo_clr = (rst_lo_q == 8'(RST_CYC)) & ~frst_n_s;

    dcf_rtx_state_t rt_state_q;
    logic [7:0] rtr_cnt_q;
    logic rtx_go;
    logic rtx_done;
    logic busy;
    assign rtx_go = (rt_state_q == DCF_RT_IDLE) & (rtx_lo_q == 8'(RTX_CYC));
    assign rtx_done = (rt_state_q == DCF_RT_RECOVER) & (rtr_cnt_q == '0) & rtx_n_s;
    assign busy = (rt_state_q != DCF_RT_IDLE);

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rt_state_q <= DCF_RT_IDLE;
            rtr_cnt_q <= '0;
        end else if (fifo_clr) begin
            rt_state_q <= DCF_RT_IDLE;
            rtr_cnt_q <= '0;
        end else begin
            case (rt_state_q)
                DCF_RT_IDLE: begin
                    if (rtx_go) begin
                        rt_state_q <= DCF_RT_RECOVER;
                        rtr_cnt_q <= 8'(RTR_CYC);
                    end
                end
                DCF_RT_RECOVER: begin
                    if (rtr_cnt_q != '0) begin
                        rtr_cnt_q <= rtr_cnt_q - 8'h01;
                    end else if (rtx_n_s) begin
                        rt_state_q <= DCF_RT_IDLE;
                    end
                end
                default: begin
                    rt_state_q <= DCF_RT_IDLE;
                end
            endcase
        end
    end

    // ****************************************************
    // Pointers and fill count
    // ****************************************************
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic w_do;
    logic r_do;

    // Accesses against an asserted indicator are dropped
    assign w_do = wclk_rise & ~wen_n_s & full_indicator_n_out & ~busy & ~fifo_clr;
    assign r_do = rclk_rise & ~ren_n_s & empty_indicator_n_out & ~busy & ~fifo_clr;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else if (fifo_clr) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else if (rtx_go) begin
            // Replay from location zero; no wrap since reset assumed
            rd_ptr_q <= '0;
            count_q <= {1'b0, wr_ptr_q};
        end else begin
            wr_ptr_q <= wr_ptr_q + AW'(w_do);
            rd_ptr_q <= rd_ptr_q + AW'(r_do);
            count_q <= count_q + (AW+1)'(w_do) - (AW+1)'(r_do);
        end
    end

    // Counts as seen by each side: the far side's same-cycle access is missed
    logic [AW:0] cnt_wside;
    logic [AW:0] cnt_rside;
    assign cnt_wside = count_q + (AW+1)'(w_do);
    assign cnt_rside = count_q - (AW+1)'(r_do);

    // ****************************************************
    // Storage
    // ****************************************************
    dcf_mem_if #(.AW(AW), .W(W)) mif ();

    assign mif.wr_en = w_do;
    assign mif.wr_addr = wr_ptr_q;
    assign mif.wr_data = data_s;
    assign mif.rd_en = r_do;
    assign mif.rd_addr = rd_ptr_q;

    dcf_mem #(.AW(AW), .W(W)) u_mem (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .mif(mif.mem)
    );

    // ****************************************************
    // Read data and output enable
    // ****************************************************
    logic rd_pend_q;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_pend_q <= 1'b0;
            data_out <= '0;
            data_oe_out <= 1'b0;
        end else begin
            rd_pend_q <= r_do;
            data_oe_out <= ~oe_n_s;
            if (fifo_clr) begin
                data_out <= '0;
            end else if (rd_pend_q) begin
                data_out <= mif.rd_data;
            end
        end
    end

    // ****************************************************
    // Full and empty, each on its own side's edge
    // ****************************************************
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            full_indicator_n_out <= `DCF_FULL_N_RST;
        end else if (fifo_clr) begin
            full_indicator_n_out <= `DCF_FULL_N_RST;
        end else if (wclk_rise || rtx_done) begin
            full_indicator_n_out <= (cnt_wside != DEPTH_C);
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            empty_indicator_n_out <= `DCF_EMPTY_N_RST;
        end else if (fifo_clr) begin
            empty_indicator_n_out <= `DCF_EMPTY_N_RST;
        end else if (rclk_rise || rtx_done) begin
            empty_indicator_n_out <= (cnt_rside != '0);
        end
    end

    // ****************************************************
    // Almost flags
    // ****************************************************
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            almost_empty_indicator_n_out <= `DCF_AE_N_RST;
        end else if (fifo_clr) begin
            almost_empty_indicator_n_out <= `DCF_AE_N_RST;
        end else if (!sync_mode) begin
            almost_empty_indicator_n_out <= (count_q > {1'b0, ae_off_s});
        end else if (rclk_rise) begin
            // Needs a read edge after recovery to refresh
            almost_empty_indicator_n_out <= (cnt_rside > {1'b0, ae_off_s});
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            almost_full_indicator_n_out <= `DCF_AF_N_RST;
        end else if (fifo_clr) begin
            almost_full_indicator_n_out <= `DCF_AF_N_RST;
        end else if (!sync_mode) begin
            almost_full_indicator_n_out <= (count_q + {1'b0, af_off_s} < DEPTH_C);
        end else if (wclk_rise) begin
            almost_full_indicator_n_out <= (cnt_wside + {1'b0, af_off_s} < DEPTH_C);
        end
    end

    // ****************************************************
    // Cascade outputs, one link-clock period wide
    // ****************************************************
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            write_cascade_out <= 1'b0;
            read_cascade_out <= 1'b0;
        end else begin
            if (wclk_rise) begin
                write_cascade_out <= w_do & f_at_last(wr_ptr_q);
            end
            if (rclk_rise) begin
                read_cascade_out <= r_do & f_at_last(rd_ptr_q);
            end
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_read_taken;
        r_do ##1 rd_pend_q;
    endsequence
    property p_first_word;
        s_read_taken |=> (data_out == $past(mif.rd_data));
    endproperty
    a_first_word: assert property (p_first_word) else $error("read word not presented");

    property p_full_edge;
        $rose(full_indicator_n_out) |-> $past(wclk_rise) || $past(rtx_done) || $past(fifo_clr);
    endproperty
    a_full_edge: assert property (p_full_edge) else $error("full released off write edge");

    property p_empty_edge;
        $rose(empty_indicator_n_out) |-> $past(rclk_rise) || $past(rtx_done);
    endproperty
    a_empty_edge: assert property (p_empty_edge) else $error("empty released off read edge");

    property p_clear_data;
        fifo_clr |=> (data_out == '0) && !empty_indicator_n_out && full_indicator_n_out;
    endproperty
    a_clear_data: assert property (p_clear_data) else $error("state after reset wrong");

    property p_ae_sync;
        sync_mode && $past(sync_mode) && !fifo_clr && $changed(almost_empty_indicator_n_out)
            |-> $past(rclk_rise) || $past(fifo_clr);
    endproperty
    a_ae_sync: assert property (p_ae_sync) else $error("almost empty moved off read edge");

    property p_af_level;
        sync_mode && wclk_rise && !fifo_clr
            |=> almost_full_indicator_n_out == ($past(count_q) + (AW+1)'($past(w_do))
                + {1'b0, $past(af_off_s)} < DEPTH_C);
    endproperty
    a_af_level: assert property (p_af_level) else $error("almost full level wrong");

    property p_wcas;
        w_do && f_at_last(wr_ptr_q) |=> write_cascade_out;
    endproperty
    a_wcas: assert property (p_wcas) else $error("write cascade missing");

    property p_rcas;
        r_do && f_at_last(rd_ptr_q) |=> read_cascade_out;
    endproperty
    a_rcas: assert property (p_rcas) else $error("read cascade missing");

    property p_no_write_full;
        wclk_rise && !full_indicator_n_out |=> $stable(wr_ptr_q) || $past(fifo_clr);
    endproperty
    a_no_write_full: assert property (p_no_write_full) else $error("write while full");

    property p_recover_hold;
        busy && !fifo_clr |=> $stable(wr_ptr_q);
    endproperty
    a_recover_hold: assert property (p_recover_hold) else $error("write during recovery");
endmodule : dcf_top
`default_nettype wire

// ---- verilog/dcf_defines.svh ----
// Purpose: Constants for the dual-clock FIFO flag and latency block
// Assumes: System clock runs at 20 MHz
// Notes: Times in ns as given; cycle counts derive from them
`ifndef DCF_DEFINES_SVH
`define DCF_DEFINES_SVH

// ****************************************************
// Geometry
// ****************************************************
`define DCF_DEPTH 16384
`define DCF_WIDTH 18

// ****************************************************
// Timing
// ****************************************************
`define DCF_CLK_NS 50
`define DCF_RST_MIN_NS 10
`define DCF_RTX_MIN_NS 30
`define DCF_RTR_NS 60
// Least time, rounded up to whole cycles, never below one
`define DCF_CEIL_CYC(ns) ((((ns) + `DCF_CLK_NS - 1) / `DCF_CLK_NS) < 1 ? 1 : \
    (((ns) + `DCF_CLK_NS - 1) / `DCF_CLK_NS))

// ****************************************************
// Reset levels of the active-low indicators
// ****************************************************
`define DCF_FULL_N_RST 1'b1
`define DCF_EMPTY_N_RST 1'b0
`define DCF_AE_N_RST 1'b0
`define DCF_AF_N_RST 1'b1

`endif

// ---- verilog/dcf_pkg.sv ----
// Purpose: Shared types of the dual-clock FIFO block
// Assumes: dcf_defines.svh supplies the word width
// Notes: None
`include "dcf_defines.svh"
package dcf_pkg;
    typedef logic [`DCF_WIDTH-1:0] dcf_word_t;
    typedef enum logic [1:0] {
        DCF_RT_IDLE = 2'h1,
        DCF_RT_RECOVER = 2'h2
    } dcf_rtx_state_t;
endpackage : dcf_pkg

// ---- verilog/dcf_mem_if.sv ----
// Purpose: Carrier between FIFO control and its storage
// Assumes: Single system clock
// Notes: Read data is registered inside the memory
`timescale 1ns/1ps
`default_nettype none
interface dcf_mem_if #(
    parameter int unsigned AW = 14,
    parameter int unsigned W = 18
);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [W-1:0] wr_data;
    logic rd_en;
    logic [AW-1:0] rd_addr;
    logic [W-1:0] rd_data;
    modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface : dcf_mem_if
`default_nettype wire

// ---- verilog/dcf_mem.sv ----
// Purpose: Simple dual-port storage array for the FIFO
// Assumes: One clock, read and write ports independent
// Notes: Read data comes out of a register one cycle after rd_en
`timescale 1ns/1ps
`default_nettype none
module dcf_mem #(
    parameter int unsigned AW = 14,
    parameter int unsigned W = 18
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Storage port
    dcf_mem_if.mem mif
);
    logic [W-1:0] ram [0:(1<<AW)-1];

    always_ff @(posedge clock_in) begin
        if (mif.wr_en) begin
            ram[mif.wr_addr] <= mif.wr_data;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mif.rd_data <= '0;
        end else if (mif.rd_en) begin
            mif.rd_data <= ram[mif.rd_addr];
        end
    end
endmodule : dcf_mem
`default_nettype wire

// ---- verif/dcf_link_model.sv ----
// Purpose: Writer and reader logic on the far side of the FIFO pins
// Assumes: Link clocks far slower than clock_in, unrelated in phase
// Notes: Enables and data change only while the link clock is low
`timescale 1ns/1ps
`default_nettype none
module dcf_link_model (
    // System clock
    input wire logic clock_in,
    // Writer pins
    output logic write_clk_out,
    output logic write_en_n_out,
    output dcf_pkg::dcf_word_t data_out,
    // Reader pins
    output logic read_clk_out,
    output logic read_en_n_out,
    input wire dcf_pkg::dcf_word_t data_in
);
    import dcf_pkg::*;

    // ****************************************************
    // Free-running link clocks, also through reset
    // ****************************************************
    initial begin
        write_clk_out = 1'b0;
        forever #200 write_clk_out = ~write_clk_out;
    end

    initial begin
        read_clk_out = 1'b0;
        #137;
        forever #200 read_clk_out = ~read_clk_out;
    end

    initial begin
        write_en_n_out = 1'b1;
        read_en_n_out = 1'b1;
        data_out = '0;
    end

    // ****************************************************
    // Transfers
    // ****************************************************
    task automatic push(input dcf_word_t w);
        @(negedge write_clk_out);
        @(posedge clock_in);
        write_en_n_out <= 1'b0;
        data_out <= w;
        @(posedge write_clk_out);
        @(negedge write_clk_out);
        @(posedge clock_in);
        write_en_n_out <= 1'b1;
        // Idle bus shows the inverse, so a stale word cannot pass
        data_out <= ~w;
        repeat (2) @(posedge clock_in);
    endtask : push

    task automatic pop(output dcf_word_t w);
        @(negedge read_clk_out);
        @(posedge clock_in);
        read_en_n_out <= 1'b0;
        @(posedge read_clk_out);
        @(negedge read_clk_out);
        @(posedge clock_in);
        read_en_n_out <= 1'b1;
        repeat (2) @(posedge clock_in);
        w = data_in;
    endtask : pop
endmodule : dcf_link_model
`default_nettype wire

// ---- verif/dual_clock_fifo_flag_timing_bench.sv ----
// Purpose: Self-checking bench of the FIFO flags, latency and cascade outputs
// Assumes: Depth shrunk to 16 so fill and drain stay short
// Notes: Sync almost-flag mode, then a short level mode pass; n = 2, m = 3 then 13
`timescale 1ns/1ps
`default_nettype none
module dual_clock_fifo_flag_timing_bench;
    import dcf_pkg::*;

    // ****************************************************
    // Signals
    // ****************************************************
    localparam int unsigned DEPTH = 16;
    localparam int unsigned AE_OFS = 2;
    localparam int unsigned AF_OFS = 3;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic fifo_reset_n = 1'b1;
    logic retransmit_n = 1'b1;
    logic oe_n = 1'b0;
    logic sync_sel = 1'b0;
    logic [3:0] ae_ofs = 4'(AE_OFS);
    logic [3:0] af_ofs = 4'(AF_OFS);
    logic wclk, rclk, wen_n, ren_n;
    logic data_oe, full_n, empty_n, ae_n, af_n, wcas, rcas;
    dcf_word_t wdata, rdata, seen;
    int errors = 0;
    int num_checks = 0;

    always #25 clock_in = ~clock_in;

    dcf_link_model link (
        .clock_in(clock_in),
        .write_clk_out(wclk),
        .write_en_n_out(wen_n),
        .data_out(wdata),
        .read_clk_out(rclk),
        .read_en_n_out(ren_n),
        .data_in(rdata)
    );

    dcf_top #(.DEPTH(DEPTH), .AW(4)) dut (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .write_clk_in(wclk),
        .write_en_n_in(wen_n),
        .data_in(wdata),
        .read_clk_in(rclk),
        .read_en_n_in(ren_n),
        .output_drive_enable_n_in(oe_n),
        .data_out(rdata),
        .data_oe_out(data_oe),
        .fifo_reset_n_in(fifo_reset_n),
        .retransmit_n_in(retransmit_n),
        .sync_flag_select_in(sync_sel),
        .almost_empty_offset_in(ae_ofs),
        .almost_full_offset_in(af_ofs),
        .full_indicator_n_out(full_n),
        .empty_indicator_n_out(empty_n),
        .almost_empty_indicator_n_out(ae_n),
        .almost_full_indicator_n_out(af_n),
        .write_cascade_out(wcas),
        .read_cascade_out(rcas)
    );

    // ****************************************************
    // Helpers
    // ****************************************************
    task automatic check(input string name, input logic [17:0] seen_v, input logic [17:0] exp_v);
        num_checks++;
        if (seen_v !== exp_v) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp_v, seen_v);
        end
    endtask : check

    task automatic flags(input logic f, input logic e, input logic ae, input logic af);
        check("full_n", full_n, f);
        check("empty_n", empty_n, e);
        check("almost_empty_n", ae_n, ae);
        check("almost_full_n", af_n, af);
    endtask : flags

    task automatic pin_reset;
        @(posedge clock_in);
        fifo_reset_n <= 1'b0;
        repeat (3) @(posedge clock_in);
        fifo_reset_n <= 1'b1;
        repeat (4) @(posedge clock_in);
    endtask : pin_reset

    task automatic wrap_up;
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    // ****************************************************
    // Tests
    // ****************************************************
    initial begin
        #400000;
        errors++;
        wrap_up();
    end

    initial begin
        repeat (3) @(posedge clock_in);
        flags(1'b1, 1'b0, 1'b0, 1'b1);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        check("data_oe", data_oe, 1'b1);
        check("data_out", rdata, 18'h0);
        link.pop(seen);
        check("empty_n", empty_n, 1'b0);
        check("data_out", rdata, 18'h0);
        link.push(18'h2a5a5);
        check("empty_n", empty_n, 1'b1);
        link.pop(seen);
        check("first word", seen, 18'h2a5a5);
        check("empty_n", empty_n, 1'b0);
        link.push(18'h15a5a);
        // Glitch falls between sampling edges, so it must not act
        @(posedge clock_in);
        #10 fifo_reset_n = 1'b0;
        #10 fifo_reset_n = 1'b1;
        repeat (4) @(posedge clock_in);
        check("empty_n", empty_n, 1'b1);
        pin_reset();
        flags(1'b1, 1'b0, 1'b0, 1'b1);
        check("data_out", rdata, 18'h0);
        for (int k = 0; k < DEPTH; k++) begin
            link.push(dcf_word_t'(32'h100 + k));
            check("almost_full_n", af_n, k + 1 + AF_OFS < DEPTH);
            check("full_n", full_n, k + 1 < DEPTH);
            check("write_cascade", wcas, k == DEPTH - 1);
        end
        link.push(18'h3ffff);
        check("full_n", full_n, 1'b0);
        for (int k = 0; k < DEPTH; k++) begin
            link.pop(seen);
            check("read data", seen, dcf_word_t'(32'h100 + k));
            check("read_cascade", rcas, k == DEPTH - 1);
            check("almost_empty_n", ae_n, DEPTH - 1 - k > AE_OFS);
            // Full refreshes on a write edge or at the end of retransmit recovery, never on a read edge
            @(posedge wclk);
            repeat (4) @(posedge clock_in);
            check("full_n", full_n, 1'b1);
        end
        check("empty_n", empty_n, 1'b0);
        repeat (20) @(posedge clock_in);
        check("almost_full_n", af_n, 1'b1);
        // Retransmit needs an unwrapped write pointer
        pin_reset();
        for (int k = 0; k < 3; k++) begin
            link.push(dcf_word_t'(32'h200 + k));
        end
        link.pop(seen);
        link.pop(seen);
        check("almost_empty_n", ae_n, 1'b0);
        @(posedge clock_in);
        retransmit_n <= 1'b0;
        repeat (3) @(posedge clock_in);
        retransmit_n <= 1'b1;
        // Flags are not trusted until recovery is over
        repeat (6) @(posedge clock_in);
        check("empty_n", empty_n, 1'b1);
        repeat (20) @(posedge clock_in);
        check("almost_empty_n", ae_n, 1'b1);
        link.pop(seen);
        check("replayed word", seen, 18'h00200);
        // Level mode: almost-full follows a read without waiting for a write edge
        sync_sel <= 1'b1;
        af_ofs <= 4'hd;
        pin_reset();
        for (int k = 0; k < 3; k++) begin
            link.push(dcf_word_t'(32'h300 + k));
        end
        check("almost_full_n", af_n, 1'b0);
        check("almost_empty_n", ae_n, 1'b1);
        link.pop(seen);
        check("read data", seen, 18'h00300);
        check("almost_full_n", af_n, 1'b1);
        oe_n <= 1'b1;
        repeat (4) @(posedge clock_in);
        check("data_oe", data_oe, 1'b0);
        wrap_up();
    end
endmodule : dual_clock_fifo_flag_timing_bench
`default_nettype wire
